// ===== sim/meas_source.sv
`timescale 1ns/100ps
// acquisition side: start pulses and math stage results for the four paths
module meas_source (
	input wire logic clock,
	output logic [dolc_pkg::NUM_PATHS-1:0] measStart,
	output logic [dolc_pkg::NUM_PATHS-1:0] mathValid,
	output logic [dolc_pkg::NUM_PATHS*dolc_pkg::DATA_W-1:0] mathData
);
	import dolc_pkg::*;
	// quiet lines from time zero
	initial begin
		measStart = '0;
		mathValid = '0;
		mathData = '0;
	end
	// one start pulse on path p
	task automatic start(input int p);
		@(posedge clock);
		measStart[p] <= 1'b1;
		@(posedge clock);
		measStart[p] <= 1'b0;
	endtask
	// n results in a row; afterwards the data shows the inverse, never stale
	task automatic burst(input int p, input logic [DATA_W-1:0] d, input int n);
		@(posedge clock);
		mathValid[p] <= 1'b1;
		mathData[p*DATA_W+:DATA_W] <= d;
		repeat (n) @(posedge clock);
		mathValid[p] <= 1'b0;
		mathData[p*DATA_W+:DATA_W] <= ~d;
	endtask
endmodule

// ===== sim/tb_display_offset_limit_checker.sv
`timescale 1ns/100ps
// bench: registers over apb, results through the acquisition model
module tb_display_offset_limit_checker;
	import dolc_pkg::*;
	logic clock = 1'b0; // 100 ns period
	logic rst_b = 1'b0; // held low at start
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd; // bus data and last read
	logic pready, pslverr, err; // answer and last error
	logic [NUM_PATHS-1:0] measStart, mathValid, resultValid, failFlag;
	logic [NUM_PATHS*DATA_W-1:0] mathData;
	logic [NUM_PATHS*RES_W-1:0] resultData;
	int errors = 0;
	int n_tests = 0;
	int cycles = 0; // timeout count
	int seed = 32'h5ab98705;

	always #50 clock = ~clock;

	display_offset_limit_checker i_display_offset_limit_checker (.clock(clock), .rst_b(rst_b),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .measStart(measStart),
		.mathValid(mathValid), .mathData(mathData), .resultValid(resultValid),
		.resultData(resultData), .failFlag(failFlag));
	meas_source i_meas_source (.clock(clock), .measStart(measStart), .mathValid(mathValid),
		.mathData(mathData));

	// counts, verdict, end of run
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// cut a hang short
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 100000) begin
			errors = errors + 1;
			final_report();
		end
	end
	// one comparison
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("BAD at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer; read data and error land in rd and err
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// request holds until a rising edge samples pready high; data taken at that edge
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	// byte address of a register of path p
	function automatic logic [7:0] ra(input int p, input logic [4:0] o);
		return {1'b0, p[1:0], o};
	endfunction
	// tally register image: count plus fail flag
	function automatic logic [31:0] tv(input int n);
		return {15'h0, n != 0, n[15:0]};
	endfunction
	// result expected: data plus offset when enabled
	function automatic logic [RES_W-1:0] expRes(input logic signed [DATA_W-1:0] d,
		input logic signed [DATA_W-1:0] o, input logic on);
		return {d[DATA_W-1], d} + (on ? {o[DATA_W-1], o} : 25'h0);
	endfunction
	// outside the limits, equal passes
	function automatic logic isFail(input logic signed [RES_W-1:0] r,
		input logic signed [DATA_W-1:0] lo, input logic signed [DATA_W-1:0] up);
		return r < lo || r > up;
	endfunction
	// let results land, then compare tally and flag of path 3
	task automatic tal(input int n);
		repeat (3) @(negedge clock);
		rdchk(ra(3, OFS_TALLY), tv(n));
		chk(32'(failFlag[3]), 32'(n != 0));
	endtask

	initial begin
		logic signed [DATA_W-1:0] d, lo, up, ofs;
		int p, k, cnt;
		repeat (6) @(posedge clock);
		rst_b <= 1'b1;
		// reset state of every path
		for (p = 0; p < NUM_PATHS; p++) begin
			rdchk(ra(p, OFS_OFFSET), 32'h0);
			rdchk(ra(p, OFS_OFFSET_EN), 32'h0);
			rdchk(ra(p, OFS_UPPER), 32'(UPPER_RST));
			rdchk(ra(p, OFS_LIMIT_CTRL), 32'h0);
			rdchk(ra(p, OFS_AUTO), 32'h101);
			rdchk(ra(p, OFS_TALLY), 32'h0);
		end
		// out-of-range offset clamps and enables; path 0 stays off
		apb(1'b1, ra(1, OFS_OFFSET), 32'h00030d40);
		rdchk(ra(1, OFS_OFFSET), 32'h000186a0);
		rdchk(ra(1, OFS_OFFSET_EN), 32'h1);
		rdchk(ra(0, OFS_OFFSET_EN), 32'h0);
		// every selector code
		for (k = 0; k < 4; k++) begin
			apb(1'b1, ra(2, OFS_PRESET), 32'(k));
			rdchk(ra(2, OFS_OFFSET), k == 1 ? 32'hfffe7960 : k == 2 ? 32'h186a0 : 32'h0);
		end
		// random results and offsets on paths 0 to 2, offset off now and then
		for (k = 0; k < 24; k++) begin
			p = k % 3;
			d = DATA_W'($random(seed) % 100000);
			ofs = DATA_W'($random(seed) % 100000);
			apb(1'b1, ra(p, OFS_OFFSET), 32'(ofs));
			if (k % 4 == 3)
				apb(1'b1, ra(p, OFS_OFFSET_EN), 32'h0);
			rdchk(ra(p, OFS_OFFSET_EN), 32'(k % 4 != 3));
			i_meas_source.burst(p, d, 1);
			@(negedge clock);
			chk(32'(resultValid[p]), 32'h1);
			@(negedge clock);
			chk(32'(resultValid[p]), 32'h0);
			chk(32'(resultData[p*RES_W+:RES_W]), 32'(expRes(d, ofs, k % 4 != 3)));
		end
		// limits on path 3 with auto-clear off
		lo = DATA_W'($random(seed) % 50000 - 50000);
		up = lo + 24'd3000;
		apb(1'b1, ra(3, OFS_LOWER), 32'(lo));
		apb(1'b1, ra(3, OFS_UPPER), 32'(up));
		apb(1'b1, ra(3, OFS_AUTO), 32'h0);
		i_meas_source.burst(3, lo - 24'd1, 1);
		tal(0);
		apb(1'b1, ra(3, OFS_LIMIT_CTRL), 32'h1);
		cnt = 0;
		for (k = 0; k < 20; k++) begin
			d = k == 0 ? lo : k == 1 ? up : k == 2 ? lo - 24'd1 : k == 3 ? up + 24'd1
				: lo + DATA_W'($random(seed) % 4000) - 24'd500;
			cnt += isFail({d[DATA_W-1], d}, lo, up);
			i_meas_source.burst(3, d, 1);
		end
		tal(cnt);
		i_meas_source.start(3);
		tal(cnt);
		// once: a single clear at the first start
		apb(1'b1, ra(3, OFS_AUTO), 32'h3);
		rdchk(ra(3, OFS_AUTO), 32'h103);
		i_meas_source.start(3);
		tal(0);
		rdchk(ra(3, OFS_AUTO), 32'h003);
		i_meas_source.burst(3, up + 24'd1, 2);
		i_meas_source.start(3);
		tal(2);
		apb(1'b1, ra(3, OFS_TALLY), 32'h0);
		tal(0);
		i_meas_source.burst(3, lo - 24'd1, 1);
		apb(1'b1, ra(3, OFS_AUTO), 32'h1);
		tal(0);
		i_meas_source.burst(3, lo - 24'd1, 1);
		i_meas_source.start(3);
		tal(0);
		// tally wraps after its maximum
		i_meas_source.burst(3, up + 24'd1, 65535);
		tal(65535);
		i_meas_source.burst(3, up + 24'd1, 1);
		tal(0);
		// enables refused at speed 200
		apb(1'b1, ra(0, OFS_OFFSET_EN), 32'h0);
		apb(1'b1, OFS_SPEED, 32'(SPEED_CONFLICT));
		apb(1'b1, ra(0, OFS_OFFSET_EN), 32'h1);
		chk(32'(err), 32'h1);
		apb(1'b1, ra(0, OFS_LIMIT_CTRL), 32'h1);
		chk(32'(err), 32'h1);
		rdchk(ra(0, OFS_OFFSET_EN), 32'h0);
		rdchk(OFS_ERROR, ERR_SETTINGS_CONFLICT);
		// unmapped address
		rdchk(8'h88, 32'h0);
		chk(32'(err), 32'h1);
		final_report();
	end
endmodule

// ===== verilog/display_offset_limit_checker.sv
`timescale 1ns/100ps
module display_offset_limit_checker (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [dolc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [dolc_pkg::NUM_PATHS-1:0] measStart,
	input wire logic [dolc_pkg::NUM_PATHS-1:0] mathValid,
	input wire logic [dolc_pkg::NUM_PATHS*dolc_pkg::DATA_W-1:0] mathData,
	output logic [dolc_pkg::NUM_PATHS-1:0] resultValid,
	output logic [dolc_pkg::NUM_PATHS*dolc_pkg::RES_W-1:0] resultData,
	output logic [dolc_pkg::NUM_PATHS-1:0] failFlag
);
	import dolc_pkg::*;

	// per-path settings
	logic signed [DATA_W-1:0] offsetVal_r [NUM_PATHS]; // display offset
	logic offsetOn_r [NUM_PATHS]; // offset enable
	logic signed [DATA_W-1:0] lowLim_r [NUM_PATHS]; // lower limit
	logic signed [DATA_W-1:0] upLim_r [NUM_PATHS]; // upper limit
	logic limitOn_r [NUM_PATHS]; // limit checking enable
	// global settings
	logic [7:0] speed_r; // measurement speed
	logic [31:0] errCode_r; // last error code
	// per-path tally state seen by reads
	logic [TALLY_W-1:0] tally [NUM_PATHS]; // fail tally values
	auto_mode_t mode [NUM_PATHS]; // auto-clear selections
	logic autoQuery [NUM_PATHS]; // auto-clear query answers
	logic [NUM_PATHS-1:0] clearNow; // immediate clear pulses
	logic [NUM_PATHS-1:0] modeWr; // auto-clear write pulses
	auto_mode_t modeNew; // decoded auto-clear write value
	// bus strobes
	logic access; // access phase
	logic wrEn; // write takes effect this edge
	logic conflictReq; // enabling write at conflicting speed
	logic [31:0] readData; // read mux
	logic readErr; // unmapped or misaligned address
	logic [1:0] selPath; // addressed path

	// true when the address hits one per-path register
	function automatic logic hitPath(input logic [ADDR_W-1:0] a, input logic [4:0] off);
		return (a < PATH_SPAN) && (a[4:0] == off);
	endfunction

	// addressed path index
	function automatic logic [1:0] pathOf(input logic [ADDR_W-1:0] a);
		return a[6:5];
	endfunction

	// offset entries saturate into the legal range
	function automatic logic signed [DATA_W-1:0] clampOffset(input logic signed [DATA_W-1:0] v);
		if (v < OFFSET_MIN) begin
			return OFFSET_MIN;
		end else if (v > OFFSET_MAX) begin
			return OFFSET_MAX;
		end else begin
			return v;
		end
	endfunction

	// selector code to offset value
	function automatic logic signed [DATA_W-1:0] presetValue(input logic [1:0] sel);
		unique case (sel)
			PRESET_MIN: return OFFSET_MIN;
			PRESET_MAX: return OFFSET_MAX;
			default: return OFFSET_DEF;
		endcase
	endfunction

	// sign extension for reads
	function automatic logic [31:0] sext(input logic signed [DATA_W-1:0] v);
		return {{(32 - DATA_W){v[DATA_W-1]}}, v};
	endfunction

	// bus phase decode
	always_comb begin
		access = psel && penable;
		wrEn = access && pwrite && pready;
		selPath = pathOf(paddr);
	end

	// any write that would switch offset or limits on at speed 200
	always_comb begin
		conflictReq = access && pwrite && (speed_r == SPEED_CONFLICT) && (
			hitPath(paddr, OFS_OFFSET) || hitPath(paddr, OFS_PRESET) ||
			(hitPath(paddr, OFS_OFFSET_EN) && pwdata[EN_BIT]) ||
			(hitPath(paddr, OFS_LIMIT_CTRL) && pwdata[EN_BIT]));
	end

	// auto-clear write decode; unused code means off
	always_comb begin
		unique case (pwdata[1:0])
			2'b01: modeNew = AUTO_ALWAYS;
			2'b11: modeNew = AUTO_ONCE;
			default: modeNew = AUTO_OFF;
		endcase
	end

	// tally clear and selection write pulses
	always_comb begin
		clearNow = '0;
		modeWr = '0;
		if (wrEn && hitPath(paddr, OFS_TALLY)) begin
			clearNow[selPath] = 1'b1;
		end
		if (wrEn && hitPath(paddr, OFS_AUTO)) begin
			modeWr[selPath] = 1'b1;
		end
	end

	// read mux; every word in the path region is mapped
	always_comb begin
		readData = '0;
		readErr = 1'b0;
		if (paddr[1:0] != 2'b00) begin
			readErr = 1'b1;
		end else if (paddr < PATH_SPAN) begin
			unique case (paddr[4:0])
				OFS_OFFSET: readData = sext(offsetVal_r[selPath]);
				OFS_OFFSET_EN: readData[EN_BIT] = offsetOn_r[selPath];
				OFS_PRESET: readData = sext(offsetVal_r[selPath]);
				OFS_LOWER: readData = sext(lowLim_r[selPath]);
				OFS_UPPER: readData = sext(upLim_r[selPath]);
				OFS_LIMIT_CTRL: readData[EN_BIT] = limitOn_r[selPath];
				OFS_AUTO: begin
					readData[1:0] = mode[selPath];
					readData[AUTO_QUERY_BIT] = autoQuery[selPath];
				end
				OFS_TALLY: begin
					readData[TALLY_W-1:0] = tally[selPath];
					readData[FAIL_FLAG_BIT] = failFlag[selPath];
				end
				default: readErr = 1'b1;
			endcase
		end else if (paddr == OFS_SPEED) begin
			readData[7:0] = speed_r;
		end else if (paddr == OFS_ERROR) begin
			readData = errCode_r;
		end else begin
			readErr = 1'b1;
		end
	end

	// one wait state: answer on the second access cycle
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			pready <= access && !pready;
			if (access && !pready) begin
				prdata <= pwrite ? 32'h00000000 : readData;
				pslverr <= readErr || conflictReq;
			end
		end
	end

	// per-path settings; rejected writes change nothing
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NUM_PATHS; i++) begin
				offsetVal_r[i] <= OFFSET_DEF;
				offsetOn_r[i] <= 1'b0;
				lowLim_r[i] <= LOWER_RST;
				upLim_r[i] <= UPPER_RST;
				limitOn_r[i] <= 1'b0;
			end
		end else if (wrEn && !conflictReq && (paddr < PATH_SPAN)) begin
			// entering a value switches the offset on
			if (hitPath(paddr, OFS_OFFSET)) begin
				offsetVal_r[selPath] <= clampOffset(pwdata[DATA_W-1:0]);
				offsetOn_r[selPath] <= 1'b1;
			end
			if (hitPath(paddr, OFS_PRESET)) begin
				offsetVal_r[selPath] <= presetValue(pwdata[1:0]);
				offsetOn_r[selPath] <= 1'b1;
			end
			if (hitPath(paddr, OFS_OFFSET_EN)) begin
				offsetOn_r[selPath] <= pwdata[EN_BIT];
			end
			if (hitPath(paddr, OFS_LOWER)) begin
				lowLim_r[selPath] <= pwdata[DATA_W-1:0];
			end
			if (hitPath(paddr, OFS_UPPER)) begin
				upLim_r[selPath] <= pwdata[DATA_W-1:0];
			end
			if (hitPath(paddr, OFS_LIMIT_CTRL)) begin
				limitOn_r[selPath] <= pwdata[EN_BIT];
			end
		end
	end

	// speed setting
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			speed_r <= SPEED_RST;
		end else if (wrEn && paddr == OFS_SPEED) begin
			speed_r <= pwdata[7:0];
		end
	end

	// error code: a conflict records -221, a write clears
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			errCode_r <= ERR_NONE;
		end else if (wrEn && conflictReq) begin
			errCode_r <= ERR_SETTINGS_CONFLICT;
		end else if (wrEn && paddr == OFS_ERROR) begin
			errCode_r <= ERR_NONE;
		end
	end

	// four independent paths with their tallies
	meas_if pathBus[NUM_PATHS] ();
	for (genvar g = 0; g < NUM_PATHS; g++) begin : gPath
		assign pathBus[g].mathValid = mathValid[g];
		assign pathBus[g].mathData = mathData[g*DATA_W +: DATA_W];
		assign pathBus[g].offsetOn = offsetOn_r[g];
		assign pathBus[g].offsetVal = offsetVal_r[g];
		assign pathBus[g].lowLim = lowLim_r[g];
		assign pathBus[g].upLim = upLim_r[g];
		assign pathBus[g].limitOn = limitOn_r[g];
		assign resultValid[g] = pathBus[g].resultValid;
		assign resultData[g*RES_W +: RES_W] = pathBus[g].resultData;

		meas_path uPath (
			.clock(clock),
			.rst_b(rst_b),
			.bus(pathBus[g])
		);

		fail_tally uTally (
			.clock(clock),
			.rst_b(rst_b),
			.failEvt(pathBus[g].outside),
			.startEvt(measStart[g]),
			.clearNow(clearNow[g]),
			.modeWr(modeWr[g]),
			.modeNew(modeNew),
			.tally(tally[g]),
			.failFlag(failFlag[g]),
			.mode(mode[g]),
			.autoQuery(autoQuery[g])
		);

		chk_value_enables: assert property (@(posedge clock) disable iff (!rst_b)
			wrEn && !conflictReq && hitPath(paddr, OFS_OFFSET) && selPath == 2'(g)
			|=> offsetOn_r[g])
			else $error("offset value write left offset disabled");
		chk_conflict_hold: assert property (@(posedge clock) disable iff (!rst_b)
			wrEn && conflictReq && selPath == 2'(g) && paddr < PATH_SPAN
			|=> $stable(offsetOn_r[g]) && $stable(limitOn_r[g]) && $stable(offsetVal_r[g]))
			else $error("conflicting write changed settings");
	end

	chk_conflict_code: assert property (@(posedge clock) disable iff (!rst_b)
		wrEn && conflictReq |=> errCode_r == ERR_SETTINGS_CONFLICT)
		else $error("conflict did not record -221");
	chk_ready_once: assert property (@(posedge clock) disable iff (!rst_b)
		access && !pready |=> pready ##1 !pready)
		else $error("ready not a single pulse after one wait state");
	cov_conflict: cover property (@(posedge clock) disable iff (!rst_b) wrEn && conflictReq);
endmodule

// ===== verilog/dolc_pkg.sv
package dolc_pkg;
	// structure
	localparam int NUM_PATHS = 4; // four independent post-math paths
	localparam int DATA_W = 24; // signed milli-dB, common to data, offset and limits
	localparam int RES_W = 25; // result after offset, one bit of headroom
	localparam int TALLY_W = 16; // fail tally width
	localparam int ADDR_W = 8; // apb byte address width
	// per-path register offsets, path base is index times 0x20
	localparam logic [4:0] OFS_OFFSET = 5'h00; // offset value, write also enables
	localparam logic [4:0] OFS_OFFSET_EN = 5'h04; // offset enable
	localparam logic [4:0] OFS_PRESET = 5'h08; // offset selector def/min/max
	localparam logic [4:0] OFS_LOWER = 5'h0c; // lower limit
	localparam logic [4:0] OFS_UPPER = 5'h10; // upper limit
	localparam logic [4:0] OFS_LIMIT_CTRL = 5'h14; // limit checking enable
	localparam logic [4:0] OFS_AUTO = 5'h18; // auto-clear selection
	localparam logic [4:0] OFS_TALLY = 5'h1c; // tally read, write clears
	localparam logic [7:0] PATH_SPAN = 8'h80; // end of the per-path region
	// global registers
	localparam logic [7:0] OFS_SPEED = 8'h80; // measurement speed setting
	localparam logic [7:0] OFS_ERROR = 8'h84; // last error code, write clears
	// field positions
	localparam int EN_BIT = 0; // enable bit of enable and control registers
	localparam int AUTO_QUERY_BIT = 8; // auto-clear query answer
	localparam int FAIL_FLAG_BIT = 16; // fail flag beside the tally
	// preset selector codes
	localparam logic [1:0] PRESET_DEF = 2'h0;
	localparam logic [1:0] PRESET_MIN = 2'h1;
	localparam logic [1:0] PRESET_MAX = 2'h2;
	// values in milli-dB
	localparam logic signed [DATA_W-1:0] OFFSET_DEF = 24'h000000; // 0 dB
	localparam logic signed [DATA_W-1:0] OFFSET_MIN = 24'hfe7960; // -100.000 dB
	localparam logic signed [DATA_W-1:0] OFFSET_MAX = 24'h0186a0; // +100.000 dB
	localparam logic signed [DATA_W-1:0] UPPER_RST = 24'h015f90; // +90.00
	localparam logic signed [DATA_W-1:0] LOWER_RST = 24'hfea070; // -90.00
	localparam logic [7:0] SPEED_RST = 8'h14; // speed 20
	localparam logic [7:0] SPEED_CONFLICT = 8'hc8; // speed 200
	localparam logic [31:0] ERR_NONE = 32'h00000000;
	localparam logic [31:0] ERR_SETTINGS_CONFLICT = 32'hffffff23; // -221
	// auto-clear selection
	typedef enum logic [1:0] {
		AUTO_OFF = 2'b00,
		AUTO_ALWAYS = 2'b01,
		AUTO_ONCE = 2'b11
	} auto_mode_t;
endpackage

// ===== verilog/fail_tally.sv
`timescale 1ns/100ps
// fail tally with immediate and automatic clearing
module fail_tally (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic failEvt,
	input wire logic startEvt,
	input wire logic clearNow,
	input wire logic modeWr,
	input wire dolc_pkg::auto_mode_t modeNew,
	output logic [dolc_pkg::TALLY_W-1:0] tally,
	output logic failFlag,
	output dolc_pkg::auto_mode_t mode,
	output logic autoQuery
);
	import dolc_pkg::*;

	logic [TALLY_W-1:0] tallyNxt; // next tally
	logic armed_r; // once mode still waiting for its first start
	logic anyClear; // any clearing cause this cycle

	// increment wraps by width; every clear wins over the increment
	always_comb begin
		anyClear = clearNow || (modeWr && modeNew == AUTO_ALWAYS) ||
			(startEvt && (mode == AUTO_ALWAYS || (mode == AUTO_ONCE && armed_r)));
		tallyNxt = tally;
		if (failEvt) begin
			tallyNxt = tally + 16'h0001;
		end
		if (anyClear) begin
			tallyNxt = '0;
		end
	end

	// tally and flag
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tally <= '0;
			failFlag <= 1'b0;
		end else begin
			tally <= tallyNxt;
			failFlag <= |tallyNxt;
		end
	end

	// selection and the once arming
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			mode <= AUTO_ALWAYS;
			armed_r <= 1'b0;
		end else if (modeWr) begin
			mode <= modeNew;
			armed_r <= (modeNew == AUTO_ONCE);
		end else if (startEvt && mode == AUTO_ONCE) begin
			armed_r <= 1'b0;
		end
	end

	// query answer: once reads 1 only until a start
	assign autoQuery = (mode == AUTO_ALWAYS) || (mode == AUTO_ONCE && armed_r);

	chk_always_clear: assert property (@(posedge clock) disable iff (!rst_b)
		startEvt && mode == AUTO_ALWAYS |=> tally == '0)
		else $error("start did not clear tally in always mode");
	chk_off_keeps: assert property (@(posedge clock) disable iff (!rst_b)
		startEvt && mode == AUTO_OFF && !failEvt && !clearNow && !modeWr |=> $stable(tally))
		else $error("start changed tally in off mode");
	chk_once_single: assert property (@(posedge clock) disable iff (!rst_b)
		startEvt && mode == AUTO_ONCE && !modeWr ##1 startEvt && failEvt && !clearNow && !modeWr
		|=> tally == $past(tally) + 16'h0001)
		else $error("once mode cleared tally a second time");
	chk_wrap_zero: assert property (@(posedge clock) disable iff (!rst_b)
		failEvt && tally == 16'hffff |=> tally == '0)
		else $error("tally did not wrap to zero");
	chk_clear_wins: assert property (@(posedge clock) disable iff (!rst_b)
		clearNow && failEvt |=> tally == '0 && !failFlag)
		else $error("increment beat immediate clear");
	chk_flag_tally: assert property (@(posedge clock) disable iff (!rst_b)
		failFlag == (tally != '0))
		else $error("fail flag disagrees with tally");
	cov_wrap: cover property (@(posedge clock) disable iff (!rst_b) failEvt && tally == 16'hffff);
	cov_once: cover property (@(posedge clock) disable iff (!rst_b)
		startEvt && mode == AUTO_ONCE && armed_r);
endmodule

// ===== verilog/meas_if.sv
`timescale 1ns/100ps
// settings and results between the register file and one measurement path
interface meas_if;
	import dolc_pkg::*;
	logic mathValid; // math stage output valid, one result per cycle while high
	logic signed [DATA_W-1:0] mathData; // math stage output
	logic offsetOn; // offset applied
	logic signed [DATA_W-1:0] offsetVal; // display offset
	logic signed [DATA_W-1:0] lowLim; // lower limit
	logic signed [DATA_W-1:0] upLim; // upper limit
	logic limitOn; // limit checking enabled
	logic resultValid; // result pulse
	logic signed [RES_W-1:0] resultData; // result with offset
	logic outside; // failed measurement pulse
	modport ctrl (output mathValid, mathData, offsetOn, offsetVal, lowLim, upLim, limitOn,
		input resultValid, resultData, outside);
	modport path (input mathValid, mathData, offsetOn, offsetVal, lowLim, upLim, limitOn,
		output resultValid, resultData, outside);
endinterface

// ===== verilog/meas_path.sv
`timescale 1ns/100ps
// offset addition after the math stage and the two limit tests
module meas_path (
	input wire logic clock,
	input wire logic rst_b,
	meas_if.path bus
);
	import dolc_pkg::*;

	logic signed [RES_W-1:0] sum; // math output plus offset
	logic signed [RES_W-1:0] lowExt; // lower limit in result format
	logic signed [RES_W-1:0] upExt; // upper limit in result format

	// offset is added only to a value the math stage has finished
	always_comb begin
		lowExt = RES_W'(bus.lowLim);
		upExt = RES_W'(bus.upLim);
		sum = RES_W'(bus.mathData) + (bus.offsetOn ? RES_W'(bus.offsetVal) : '0);
	end

	// result register and the fail decision in one cycle
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			bus.resultValid <= 1'b0;
			bus.resultData <= '0;
			bus.outside <= 1'b0;
		end else begin
			bus.resultValid <= bus.mathValid;
			if (bus.mathValid) begin
				bus.resultData <= sum;
			end
			// equal to a limit passes; strictly outside fails
			bus.outside <= bus.mathValid && bus.limitOn && ((sum < lowExt) || (sum > upExt));
		end
	end

	chk_below_fails: assert property (@(posedge clock) disable iff (!rst_b)
		bus.mathValid && bus.limitOn && (sum < lowExt) |=> bus.outside)
		else $error("result below lower limit did not fail");
	chk_above_fails: assert property (@(posedge clock) disable iff (!rst_b)
		bus.mathValid && bus.limitOn && (sum > upExt) |=> bus.outside && bus.resultValid)
		else $error("result above upper limit did not fail");
	chk_limit_pass: assert property (@(posedge clock) disable iff (!rst_b)
		bus.resultValid && (bus.resultData >= $past(lowExt)) && (bus.resultData <= $past(upExt))
		|-> !bus.outside)
		else $error("result within limits counted as failure");
	chk_offset_after: assert property (@(posedge clock) disable iff (!rst_b)
		bus.mathValid && bus.offsetOn |=>
		bus.resultData == $past(RES_W'(bus.mathData)) + $past(RES_W'(bus.offsetVal)))
		else $error("offset not added to math output");
	cov_outside: cover property (@(posedge clock) disable iff (!rst_b) bus.outside);
endmodule
